/* File: rtl/ebox_ipr_bank.sv */
// Execution-unit processor registers: cycle counter and fault address formatting.
// Assumes privileged move-to/move-from strobes and memory-pipe inputs on CLK.
`timescale 1ns/1ps
module ebox_ipr_bank #(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input  wire logic                               CLK,
    input  wire logic                               SYS_RST,
    // Processor register port
    input  wire logic                               IPR_WR,
    input  wire logic                               IPR_RD,
    input  wire logic [ebox_ipr_pkg::INDEX_W-1:0]   IPR_IDX,
    input  wire logic [WIDTH-1:0]                   IPR_WDATA,
    output logic      [WIDTH-1:0]                   IPR_RDATA,
    output logic                                    IPR_RVALID,
    // Read cycle count instruction
    input  wire logic                               READ_CYCLE_COUNT_INSTR_REQ,
    output logic      [WIDTH-1:0]                   READ_CYCLE_COUNT_INSTR_DATA,
    output logic                                    READ_CYCLE_COUNT_INSTR_VALID,
    // Fault capture from the data translation buffer
    input  wire logic                               FAULT_VALID,
    input  wire logic                               FAULT_PTE_LOAD,
    input  wire logic [WIDTH-1:0]                   FAULT_ADDR,
    // Sign-extension checker
    input  wire logic                               CHK_VALID,
    input  wire logic [WIDTH-1:0]                   CHK_ADDR,
    output logic                                    CHK_ACV,
    // Byte extract/insert/mask shift amount
    input  wire logic [2:0]                         SHIFT_IN,
    output logic      [2:0]                         SHIFT_OUT,
    // Data-stream physical address low bits
    input  wire logic [2:0]                         PA_LOW_IN,
    input  wire logic [1:0]                         PA_SIZE,
    output logic      [2:0]                         PA_LOW_OUT,
    // Control state visible to the rest of the core
    output logic                                    COUNT_ENABLED,
    output logic                                    BIG_ENDIAN,
    output logic                                    WIDE_ADDRESS
);
    import ebox_ipr_pkg::*;

    // Block map, for the next reader:
    // - Register port decode and read mux
    // - Cycle counter in its own module
    // - Fault address capture
    // - Address control storage
    // - Entry address formatting module
    // - Sign-extension checker
    // - Big-endian shift and lane inversion
    // Every output is registered except the
    // three control levels, which are plain
    // copies of stored flip-flops anyway.
    //
    // Timing summary:
    // - Writes take effect at the strobe edge
    // - Reads answer one cycle later
    // - Pipe-side paths answer one cycle later
    // A read and a write in one cycle see the
    // old value, since the mux reads stored
    // state before the edge updates it.

    // Decoded write strobes
    logic             wr_count;      // Write to cycle_count_reg
    logic             wr_cnt_ctl;    // Write to count_control_reg
    logic             wr_addr_ctl;   // Write to address_control_reg

    // Stored state
    logic [WIDTH-1:0] count_value;   // Full counter, both halves
    logic [WIDTH-1:0] fault_address; // fault_address_reg
    logic [WIDTH-1:0] address_ctl;   // address_control_reg
    logic [WIDTH-1:0] formatted;     // Live formatted entry address

    // Combinational next values for the read port and pipe-side outputs
    logic             next_acv;
    logic [2:0]       next_pa_low;
    logic [WIDTH-1:0] next_rdata;

    // Index match, shared by the write decode and the read mux.
    // Full compare of all index bits; aliasing of
    // unused indices onto real registers would let
    // a stray write disturb the counter.
    function automatic logic hit(input logic [INDEX_W-1:0] idx,
                                 input logic [INDEX_W-1:0] target);
        hit = (idx == target);
    endfunction : hit

    // Sign-extension test: true when every bit above the sign bit matches it.
    // Both widths are built and compared; the mode
    // bit only picks the result, so the mux sits at
    // the very end of the path.
    function automatic logic sign_ok(input logic [WIDTH-1:0] addr,
                                     input logic            wide);
        logic [WIDTH-1:0] wide_ext;
        logic [WIDTH-1:0] narrow_ext;
        wide_ext   = {{(WIDTH-WIDE_SIGN_BIT-1){addr[WIDE_SIGN_BIT]}}, addr[WIDE_SIGN_BIT:0]};
        narrow_ext = {{(WIDTH-NARROW_SIGN_BIT-1){addr[NARROW_SIGN_BIT]}}, addr[NARROW_SIGN_BIT:0]};
        sign_ok    = wide ? (addr == wide_ext) : (addr == narrow_ext);
    endfunction : sign_ok

    // Write decode; read-only indices ignore writes.
    // No error is signalled for a refused write;
    // software learns nothing from the port.
    assign wr_count    = IPR_WR && hit(IPR_IDX, IDX_CYCLE_COUNT);
    assign wr_cnt_ctl  = IPR_WR && hit(IPR_IDX, IDX_COUNT_CONTROL);
    assign wr_addr_ctl = IPR_WR && hit(IPR_IDX, IDX_ADDRESS_CTL);

    // Counter halves and enable.
    // The upper write strobe never reaches the
    // counting half, so an offset update cannot
    // lose a count in flight.
    cycle_counter #(
        .WIDTH      (WIDTH)
    ) u_counter (
        .CLK        (CLK),
        .SYS_RST    (SYS_RST),
        .WR_UPPER   (wr_count),
        .WR_CONTROL (wr_cnt_ctl),
        .WDATA      (IPR_WDATA),
        .COUNT      (count_value),
        .ENABLED    (COUNT_ENABLED)
    );

    // Entry address formatting from the captured fault address.
    // Kept combinational: the read flop below
    // registers it, so no extra stage is paid.
    va_format u_format (
        .FAULT_ADDR (fault_address),
        .CONTROL    (address_ctl),
        .FORMATTED  (formatted)
    );

    // Address control register; reserved bits 29:3 kept clear.
    // Clearing them means no reserved bit can ever
    // leak into the formatted address.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            address_ctl <= CTL_RESET;
        end else if (wr_addr_ctl) begin
            address_ctl <= {IPR_WDATA[PTB_HI:PTB_LO], 27'h0, IPR_WDATA[FMT32_BIT:BIG_END_BIT]};
        end
    end

    assign BIG_ENDIAN   = address_ctl[BIG_END_BIT];
    assign WIDE_ADDRESS = address_ctl[WIDE_BIT];

    // Fault address capture; page entry loads leave it alone so the
    // outer fault handler still sees the address that started the walk
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fault_address <= FAULT_RESET;
        end else if (FAULT_VALID && !FAULT_PTE_LOAD) begin
            fault_address <= FAULT_ADDR;
        end
    end

    // Read multiplexer; write-only and unmapped indices read as zero.
    // The count enable and the big-endian and wide bits are still visible on
    // the level outputs, just not through a read.
    always_comb begin
        next_rdata = READ_UNMAPPED;
        if (hit(IPR_IDX, IDX_CYCLE_COUNT)) begin
            next_rdata = count_value;
        end else if (hit(IPR_IDX, IDX_FAULT_ADDRESS)) begin
            next_rdata = fault_address;
        end else if (hit(IPR_IDX, IDX_FORMATTED)) begin
            next_rdata = formatted;
        end
    end

    // Register read answer, one cycle after the strobe.
    // Data holds between reads, so a slow consumer
    // may sample it any time before the next one.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IPR_RDATA  <= READ_UNMAPPED;
            IPR_RVALID <= 1'b0;
        end else begin
            IPR_RVALID <= IPR_RD;
            if (IPR_RD) begin
                IPR_RDATA <= next_rdata;
            end
        end
    end

    // Read cycle count answer, full 64 bits, one cycle after the request.
    // Both halves come from one edge; the lower half
    // wraps with no carry into the upper half.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            READ_CYCLE_COUNT_INSTR_DATA  <= COUNT_RESET;
            READ_CYCLE_COUNT_INSTR_VALID <= 1'b0;
        end else begin
            READ_CYCLE_COUNT_INSTR_VALID <= READ_CYCLE_COUNT_INSTR_REQ;
            if (READ_CYCLE_COUNT_INSTR_REQ) begin
                READ_CYCLE_COUNT_INSTR_DATA <= count_value;
            end
        end
    end

    // Sign-extension checker, mode from the wide address bit.
    // Mode change takes effect on the cycle after
    // the control write; a check in that same
    // cycle still uses the old mode.
    assign next_acv = CHK_VALID && !sign_ok(CHK_ADDR, address_ctl[WIDE_BIT]);

    // Registered violation flag, one-cycle pulse per failing checked address
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            CHK_ACV <= 1'b0;
        end else begin
            CHK_ACV <= next_acv;
        end
    end

    // Registered shift amount; inverted in big-endian mode.
    // Inverting all three bits mirrors the byte
    // position within the quadword.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            SHIFT_OUT <= 3'h0;
        end else begin
            SHIFT_OUT <= address_ctl[BIG_END_BIT] ? ~SHIFT_IN : SHIFT_IN;
        end
    end

    // Low address inversion mask by access size; quadwords untouched.
    // Size codes outside the three narrow sizes
    // fall to the default branch and pass through.
    always_comb begin
        next_pa_low = PA_LOW_IN;
        if (address_ctl[BIG_END_BIT]) begin
            case (access_size_e'(PA_SIZE))
                SIZE_BYTE: begin
                    next_pa_low = PA_LOW_IN ^ 3'h7;
                end
                SIZE_WORD: begin
                    next_pa_low = PA_LOW_IN ^ 3'h6;
                end
                SIZE_LONG: begin
                    next_pa_low = PA_LOW_IN ^ 3'h4;
                end
                default: begin
                    next_pa_low = PA_LOW_IN;
                end
            endcase
        end
    end

    // Registered physical address low bits.
    // Registered even in little-endian mode, so the
    // latency does not depend on the mode bit.
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PA_LOW_OUT <= 3'h0;
        end else begin
            PA_LOW_OUT <= next_pa_low;
        end
    end

endmodule : ebox_ipr_bank

/* File: rtl/ebox_ipr_pkg.sv */
// Shared constants for the execution-unit processor register bank.
// Assumes a 64-bit move-to/move-from register port with an 8-bit index.
package ebox_ipr_pkg;

    // Register indices on the processor register port
    localparam logic [7:0] IDX_CYCLE_COUNT   = 8'hc0;  // cycle_count_reg, read/write
    localparam logic [7:0] IDX_COUNT_CONTROL = 8'hc1;  // count_control_reg, write only
    localparam logic [7:0] IDX_FAULT_ADDRESS = 8'hc2;  // fault_address_reg, read only
    localparam logic [7:0] IDX_ADDRESS_CTL   = 8'hc4;  // address_control_reg, write only
    localparam logic [7:0] IDX_FORMATTED     = 8'hc3;  // formatted_entry_address_reg, read only

    // Widths
    localparam int DATA_W  = 64;
    localparam int HALF_W  = 32;
    localparam int INDEX_W = 8;

    // Count control fields
    localparam int CNT_ENABLE_BIT = 32;  // count_enable_bit
    localparam int CNT_LOAD_HI    = 31;  // Loadable count field, top
    localparam int CNT_LOAD_LO    = 4;   // Loadable count field, bottom

    // Address control fields
    localparam int PTB_HI        = 63;   // page_table_base top
    localparam int PTB_LO        = 30;   // page_table_base bottom
    localparam int FMT32_BIT     = 2;    // format_32_select
    localparam int WIDE_BIT      = 1;    // wide_address_select
    localparam int BIG_END_BIT   = 0;    // Big-endian lane inversion

    // Sign-extension source bits
    localparam int WIDE_SIGN_BIT   = 47;
    localparam int NARROW_SIGN_BIT = 42;

    // Page entry scaling
    localparam int PAGE_SHIFT = 13;      // Page offset width
    localparam int PTE_SHIFT  = 3;       // Entry size of eight bytes

    // Reset values
    localparam logic [63:0] CTL_RESET   = 64'h0;
    localparam logic [63:0] COUNT_RESET = 64'h0;
    localparam logic [63:0] FAULT_RESET = 64'h0;
    localparam logic [63:0] READ_UNMAPPED = 64'h0;

    // Data-stream access sizes
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'b00,
        SIZE_WORD = 2'b01,
        SIZE_LONG = 2'b11,
        SIZE_QUAD = 2'b10
    } access_size_e;

endpackage : ebox_ipr_pkg

/* File: rtl/cycle_counter.sv */
// Cycle counter: counting lower half plus offset storage in the upper half.
// Assumes one-cycle write strobes from the owning register bank.
`timescale 1ns/1ps
module cycle_counter #(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input  wire logic             CLK,
    input  wire logic             SYS_RST,
    // Write strobes and data
    input  wire logic             WR_UPPER,
    input  wire logic             WR_CONTROL,
    input  wire logic [WIDTH-1:0] WDATA,
    // Counter value and enable state
    output logic      [WIDTH-1:0] COUNT,
    output logic                  ENABLED
);
    import ebox_ipr_pkg::*;

    localparam int H = WIDTH / 2;

    logic [H-1:0] lower;  // Counting half
    logic [H-1:0] upper;  // Offset storage, never counts

    // Enable flag loaded by each control write
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ENABLED <= 1'b0;
        end else if (WR_CONTROL) begin
            ENABLED <= WDATA[CNT_ENABLE_BIT];
        end
    end

    // Lower half: control write loads, else counts while enabled
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lower <= COUNT_RESET[H-1:0];
        end else if (WR_CONTROL) begin
            // Low nibble forced clear on every control write
            lower <= {WDATA[CNT_LOAD_HI:CNT_LOAD_LO], 4'h0};
        end else if (ENABLED) begin
            lower <= lower + 1'b1;
        end
    end

    // Upper half: plain storage, only the upper write reaches it
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            upper <= COUNT_RESET[WIDTH-1:H];
        end else if (WR_UPPER) begin
            upper <= WDATA[WIDTH-1:H];
        end
    end

    assign COUNT = {upper, lower};

endmodule : cycle_counter

/* File: rtl/va_format.sv */
// Builds the page-table-entry address from the fault address and control.
// Purely combinational; the register bank registers the result on read.
`timescale 1ns/1ps
module va_format (
    // Inputs
    input  wire logic [63:0] FAULT_ADDR,
    input  wire logic [63:0] CONTROL,
    // Formatted address
    output logic      [63:0] FORMATTED
);
    import ebox_ipr_pkg::*;

    logic [PTB_HI:PTB_LO] base;  // page_table_base

    assign base = CONTROL[PTB_HI:PTB_LO];

    // Pick the layout from the two format bits
    always_comb begin
        if (CONTROL[FMT32_BIT] && !CONTROL[WIDE_BIT]) begin
            // 32-bit layout: full base, 19-bit page number
            FORMATTED = {base, 8'h0, FAULT_ADDR[31:PAGE_SHIFT], 3'h0};
        end else if (CONTROL[WIDE_BIT]) begin
            // 48-bit layout; also taken when both bits set, no layout exists there
            FORMATTED = {base[63:38], FAULT_ADDR[47:PAGE_SHIFT], 3'h0};
        end else begin
            // 43-bit layout
            FORMATTED = {base[63:33], FAULT_ADDR[42:PAGE_SHIFT], 3'h0};
        end
    end

endmodule : va_format

/* File: tb/ebox_ipr_monitor.sv */
// Port checker for the execution-unit processor register bank.
// Assumes it is bound to ebox_ipr_bank and shares its clock and reset.
`timescale 1ns/1ps
module ebox_ipr_monitor
    import ebox_ipr_pkg::*;
#(
    parameter int WIDTH = 64
) (
    // Clock and reset
    input wire logic             CLK,
    input wire logic             SYS_RST,
    // Register port and count read
    input wire logic             IPR_WR,
    input wire logic             IPR_RD,
    input wire logic [7:0]       IPR_IDX,
    input wire logic [WIDTH-1:0] IPR_WDATA,
    input wire logic             IPR_RVALID,
    input wire logic             READ_CYCLE_COUNT_INSTR_REQ,
    input wire logic [WIDTH-1:0] READ_CYCLE_COUNT_INSTR_DATA,
    input wire logic             READ_CYCLE_COUNT_INSTR_VALID,
    // Checker and lane paths
    input wire logic             CHK_VALID,
    input wire logic [WIDTH-1:0] CHK_ADDR,
    input wire logic             CHK_ACV,
    input wire logic [2:0]       SHIFT_IN,
    input wire logic [2:0]       SHIFT_OUT,
    input wire logic [2:0]       PA_LOW_IN,
    input wire logic [1:0]       PA_SIZE,
    input wire logic [2:0]       PA_LOW_OUT,
    // Control state
    input wire logic             COUNT_ENABLED,
    input wire logic             BIG_ENDIAN,
    input wire logic             WIDE_ADDRESS
);
    default clocking mon_clk @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // Address that is not a sign extension of its top valid bit
    function automatic logic sext_bad(input logic [WIDTH-1:0] a, input logic w);
        return w ? (a[63:47] != {17{a[47]}}) : (a[63:42] != {22{a[42]}});
    endfunction : sext_bad

    // Low address bits flipped per access size; quadwords untouched
    function automatic logic [2:0] lane_mask(input logic [1:0] s);
        return (s == 2'h0) ? 3'h7 : (s == 2'h1) ? 3'h6 : (s == 2'h3) ? 3'h4 : 3'h0;
    endfunction : lane_mask

    a_read_answer: assert property (!$past(SYS_RST) |-> IPR_RVALID == $past(IPR_RD))
        else $error("read answer not one cycle after request");
    a_read_cycle_count_instr_answer: assert property (READ_CYCLE_COUNT_INSTR_REQ |=> READ_CYCLE_COUNT_INSTR_VALID)
        else $error("count read not answered");
    // Back-to-back count reads see one step per enabled cycle
    a_count_steps: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2) && $past(READ_CYCLE_COUNT_INSTR_REQ) && $past(READ_CYCLE_COUNT_INSTR_REQ, 2)
        && !$past(IPR_WR, 2) |-> READ_CYCLE_COUNT_INSTR_DATA[31:0] == $past(READ_CYCLE_COUNT_INSTR_DATA[31:0]) + {31'h0, $past(COUNT_ENABLED, 2)})
        else $error("lower count did not step by enable");
    a_upper_stays: assert property (!$past(SYS_RST) && !$past(SYS_RST, 2) && $past(READ_CYCLE_COUNT_INSTR_REQ) && $past(READ_CYCLE_COUNT_INSTR_REQ, 2)
        && !$past(IPR_WR, 2) |-> READ_CYCLE_COUNT_INSTR_DATA[63:32] == $past(READ_CYCLE_COUNT_INSTR_DATA[63:32]))
        else $error("upper count half moved");
    a_enable_load: assert property (IPR_WR && IPR_IDX == IDX_COUNT_CONTROL |=> COUNT_ENABLED == $past(IPR_WDATA[32]))
        else $error("enable not taken from bit 32");
    a_mode_load: assert property (IPR_WR && IPR_IDX == IDX_ADDRESS_CTL
        |=> WIDE_ADDRESS == $past(IPR_WDATA[1]) && BIG_ENDIAN == $past(IPR_WDATA[0]))
        else $error("address mode bits not loaded");
    a_acv_sext: assert property (!$past(SYS_RST)
        |-> CHK_ACV == ($past(CHK_VALID) && sext_bad($past(CHK_ADDR), $past(WIDE_ADDRESS))))
        else $error("violation flag wrong");
    a_shift_invert: assert property (!$past(SYS_RST)
        |-> SHIFT_OUT == ($past(SHIFT_IN) ^ {3{$past(BIG_ENDIAN)}}))
        else $error("shift amount inversion wrong");
    a_lane_invert: assert property (!$past(SYS_RST)
        |-> PA_LOW_OUT == ($past(PA_LOW_IN) ^ ($past(BIG_ENDIAN) ? lane_mask($past(PA_SIZE)) : 3'h0)))
        else $error("address lane inversion wrong");
endmodule : ebox_ipr_monitor

bind ebox_ipr_bank ebox_ipr_monitor #(.WIDTH(WIDTH)) mon_u (.CLK(CLK), .SYS_RST(SYS_RST), .IPR_WR(IPR_WR),
    .IPR_RD(IPR_RD), .IPR_IDX(IPR_IDX), .IPR_WDATA(IPR_WDATA), .IPR_RVALID(IPR_RVALID), .READ_CYCLE_COUNT_INSTR_REQ(READ_CYCLE_COUNT_INSTR_REQ),
    .READ_CYCLE_COUNT_INSTR_DATA(READ_CYCLE_COUNT_INSTR_DATA), .READ_CYCLE_COUNT_INSTR_VALID(READ_CYCLE_COUNT_INSTR_VALID), .CHK_VALID(CHK_VALID), .CHK_ADDR(CHK_ADDR), .CHK_ACV(CHK_ACV),
    .SHIFT_IN(SHIFT_IN), .SHIFT_OUT(SHIFT_OUT), .PA_LOW_IN(PA_LOW_IN), .PA_SIZE(PA_SIZE), .PA_LOW_OUT(PA_LOW_OUT),
    .COUNT_ENABLED(COUNT_ENABLED), .BIG_ENDIAN(BIG_ENDIAN), .WIDE_ADDRESS(WIDE_ADDRESS));

/* File: tb/test_ebox_ipr_bank.sv */
// Self-checking bench for the processor register bank.
// Assumes the monitor is bound; inputs change on falling edges.
`timescale 1ns/1ps
module test_ebox_ipr_bank;
    import ebox_ipr_pkg::*;
    logic        CLK = 1'b0, SYS_RST = 1'b1, IPR_WR = 1'b0, IPR_RD = 1'b0, READ_CYCLE_COUNT_INSTR_REQ = 1'b0;
    logic        FAULT_VALID = 1'b0, FAULT_PTE_LOAD = 1'b0, CHK_VALID = 1'b0;
    logic [7:0]  IPR_IDX = 8'h0;
    logic [63:0] IPR_WDATA = 64'h0, FAULT_ADDR = 64'h0, CHK_ADDR = 64'h0, IPR_RDATA, READ_CYCLE_COUNT_INSTR_DATA;
    logic [2:0]  SHIFT_IN = 3'h0, PA_LOW_IN = 3'h0, SHIFT_OUT, PA_LOW_OUT;
    logic [1:0]  PA_SIZE = 2'h0;
    logic        IPR_RVALID, READ_CYCLE_COUNT_INSTR_VALID, CHK_ACV, COUNT_ENABLED, BIG_ENDIAN, WIDE_ADDRESS;
    int          errors = 0, checks = 0;
    logic [63:0] fault_a = 64'h0000_7a5a_c3c3_e000;   // Fault address with distinct fields
    logic [63:0] ptb = 64'hfedc_ba98_c000_0000;       // Table base in bits 63:30
    logic [7:0]  idx_list [6] = '{IDX_CYCLE_COUNT, IDX_COUNT_CONTROL, IDX_FAULT_ADDRESS, IDX_FORMATTED,
                                  IDX_ADDRESS_CTL, 8'h55};
    logic [2:0]  lmask [4] = '{3'h7, 3'h6, 3'h0, 3'h4};  // By size code 00,01,10,11

    ebox_ipr_bank #(.WIDTH(64)) dut_u (.CLK(CLK), .SYS_RST(SYS_RST), .IPR_WR(IPR_WR), .IPR_RD(IPR_RD),
        .IPR_IDX(IPR_IDX), .IPR_WDATA(IPR_WDATA), .IPR_RDATA(IPR_RDATA), .IPR_RVALID(IPR_RVALID),
        .READ_CYCLE_COUNT_INSTR_REQ(READ_CYCLE_COUNT_INSTR_REQ), .READ_CYCLE_COUNT_INSTR_DATA(READ_CYCLE_COUNT_INSTR_DATA), .READ_CYCLE_COUNT_INSTR_VALID(READ_CYCLE_COUNT_INSTR_VALID), .FAULT_VALID(FAULT_VALID),
        .FAULT_PTE_LOAD(FAULT_PTE_LOAD), .FAULT_ADDR(FAULT_ADDR), .CHK_VALID(CHK_VALID), .CHK_ADDR(CHK_ADDR),
        .CHK_ACV(CHK_ACV), .SHIFT_IN(SHIFT_IN), .SHIFT_OUT(SHIFT_OUT), .PA_LOW_IN(PA_LOW_IN), .PA_SIZE(PA_SIZE),
        .PA_LOW_OUT(PA_LOW_OUT), .COUNT_ENABLED(COUNT_ENABLED), .BIG_ENDIAN(BIG_ENDIAN),
        .WIDE_ADDRESS(WIDE_ADDRESS));

    // 125 MHz clock
    initial begin
        forever #4 CLK = ~CLK;
    end

    // Four-state compare so an unknown never matches
    task check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Each access spans two falling edges; the request is taken between them
    task ipr_write(input logic [7:0] idx, input logic [63:0] d);
        @(negedge CLK) {IPR_WR, IPR_IDX, IPR_WDATA} = {1'b1, idx, d};
        @(negedge CLK) IPR_WR = 1'b0;
    endtask : ipr_write

    task ipr_read(input logic [7:0] idx, input logic [63:0] exp);
        @(negedge CLK) {IPR_RD, IPR_IDX} = {1'b1, idx};
        @(negedge CLK);
        check({63'h0, IPR_RVALID}, 64'h1);
        check(IPR_RDATA, exp);
        IPR_RD = 1'b0;
    endtask : ipr_read

    // Request held for n cycles, one answer checked per cycle
    task read_cycle_count_instr_run(input int n, input logic [63:0] first, input logic [63:0] step);
        @(negedge CLK) READ_CYCLE_COUNT_INSTR_REQ = 1'b1;
        for (int k = 0; k < n; k++) begin
            @(negedge CLK);
            check({63'h0, READ_CYCLE_COUNT_INSTR_VALID}, 64'h1);
            check(READ_CYCLE_COUNT_INSTR_DATA, first + 64'(k) * step);
        end
        READ_CYCLE_COUNT_INSTR_REQ = 1'b0;
    endtask : read_cycle_count_instr_run

    task fault(input logic [63:0] a, input logic pte);
        @(negedge CLK) {FAULT_VALID, FAULT_PTE_LOAD, FAULT_ADDR} = {1'b1, pte, a};
        @(negedge CLK) FAULT_VALID = 1'b0;
    endtask : fault

    task chk(input logic [63:0] a, input logic exp);
        @(negedge CLK) {CHK_VALID, CHK_ADDR} = {1'b1, a};
        @(negedge CLK) check({63'h0, CHK_ACV}, {63'h0, exp});
        CHK_VALID = 1'b0;
    endtask : chk

    // Expected entry address per format bits
    function automatic logic [63:0] fmt(input logic [63:0] c, input logic [63:0] a);
        if (c[1]) return {c[63:38], a[47:13], 3'h0};
        if (c[2]) return {c[63:30], 8'h0, a[31:13], 3'h0};
        return {c[63:33], a[42:13], 3'h0};
    endfunction : fmt

    task print_verdict;
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Hang guard, well beyond the fewer than 100 cycles of the sequence
    initial begin
        #40000;
        errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (10) @(negedge CLK);
        SYS_RST = 1'b0;
        foreach (idx_list[i]) ipr_read(idx_list[i], 64'h0);
        ipr_write(IDX_COUNT_CONTROL, 64'h1_0000_1235);
        read_cycle_count_instr_run(3, 64'h1231, 64'h1);
        ipr_write(IDX_CYCLE_COUNT, 64'hdead_beef_ffff_ffff);
        read_cycle_count_instr_run(2, 64'hdead_beef_0000_1237, 64'h1);
        ipr_read(IDX_CYCLE_COUNT, 64'hdead_beef_0000_123a);
        ipr_write(IDX_COUNT_CONTROL, 64'h0000_0ff8);
        read_cycle_count_instr_run(2, 64'hdead_beef_0000_0ff0, 64'h0);
        fault(fault_a, 1'b0);
        ipr_read(IDX_FAULT_ADDRESS, fault_a);
        fault(64'h1234_5678, 1'b1);
        ipr_write(IDX_FAULT_ADDRESS, 64'h5555);
        ipr_read(IDX_FAULT_ADDRESS, fault_a);
        for (int m = 0; m < 3; m++) begin
            ipr_write(IDX_ADDRESS_CTL, ptb | (64'h1 << m) & 64'h6);
            ipr_read(IDX_FORMATTED, fmt(ptb | (64'h1 << m) & 64'h6, fault_a));
        end
        ipr_write(IDX_ADDRESS_CTL, 64'h1);
        for (int s = 0; s < 4; s++) begin
            @(negedge CLK) {SHIFT_IN, PA_LOW_IN, PA_SIZE} = {3'(s + 3), 3'h5, 2'(s)};
            @(negedge CLK) check({61'h0, SHIFT_OUT}, {61'h0, ~3'(s + 3)});
            check({61'h0, PA_LOW_OUT}, {61'h0, 3'h5 ^ lmask[s]});
        end
        chk(64'h0000_0400_0000_0000, 1'b1);
        ipr_write(IDX_ADDRESS_CTL, 64'h2);
        @(negedge CLK) check({61'h0, PA_LOW_OUT}, 64'h5);
        chk(64'h0000_0400_0000_0000, 1'b0);
        chk(64'h0000_8000_0000_0000, 1'b1);
        chk(64'hffff_8000_0000_0000, 1'b0);
        ipr_read(IDX_ADDRESS_CTL, 64'h0);
        ipr_read(IDX_COUNT_CONTROL, 64'h0);
        print_verdict();
    end
endmodule : test_ebox_ipr_bank
